/* File: hhpsc_ctrl.sv */
// Hub power state control: snoop enable, clock gating, host clock, self refresh, ratio change
//
// Functional notes
// [RL1] Outside controller asserts stop-clock for C2, deasserts it in C0.
// [RL2] Snoops stay enabled in C0, C1 and C2.
// [RL3] Outside agents issue only special cycles during C3.
// [RL4] No snoops are sent while in C3.
// [RL5] C4 handled identically to C3, with no C4-specific behaviour.
// [RL6] Core ratio change happens only while processor clock stopped in C3.
// [RL7] Ratio change starts only on mains attach or removal, max or battery.
// [RL8] S2 is not supported; a request for it is ignored. Code holds RUN, SUSP and MEMRET but drops GRANT and DEEP to RUN.
// [RL9] In C2 clock gating is applied, including during snoop activity.
// [RL10] In suspend-to-memory memory contents are retained for resume.
// [RL11] C3/C4 keep host clock, memory self refresh; sleep states stop host clock.
`default_nettype none
module hhpsc_ctrl (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rstn,
	input  wire logic       i_clk_en,
	input  wire logic [3:0] i_power_state,
	input  wire logic       i_stop_clock_request,
	input  wire logic       i_mains_present,
	output logic            o_snoop_enable,
	output logic            o_clock_gate,
	output logic            o_hub_host_clock_run,
	output logic            o_self_refresh,
	output logic            o_ratio_step,
	output logic            o_ratio_mode,
	output logic            o_memory_retain,
	output logic [5:0]      o_state
);
	hhpsc_pkg::hhpsc_regs_type r;
	hhpsc_pkg::hhpsc_regs_type next_r;
	logic                      deep_req;
	logic                      grant_req;
	logic                      sleep_req;

	always_comb begin
		// C4 folds into the same request as C3; no separate path exists
		deep_req  = (i_power_state == hhpsc_pkg::PS_C3) ||
			(i_power_state == hhpsc_pkg::PS_C4); // see [RL5]
		grant_req = (i_power_state == hhpsc_pkg::PS_C2) || i_stop_clock_request; // see [RL1]
		// S2 decodes to no request: RUN, SUSP and MEMRET hold, while GRANT and DEEP drop back to RUN
		sleep_req = (i_power_state == hhpsc_pkg::PS_MOBILE_POWERED_SUSPEND) ||
			(i_power_state == hhpsc_pkg::PS_S3) ||
			(i_power_state == hhpsc_pkg::PS_S4) ||
			(i_power_state == hhpsc_pkg::PS_S5); // see [RL8]
		next_r = r;
		next_r.ctrl.ratio_step = 1'b0;
		// Mains edge latches a pending change until the clock is stopped
		if (i_mains_present != r.mains_seen) begin
			next_r.mains_seen    = i_mains_present;
			next_r.ratio_pending = 1'b1; // see [RL7]
		end
		case (r.state)
			hhpsc_pkg::ST_RUN: begin
				if (sleep_req) begin
					next_r.state = hhpsc_pkg::ST_SUSP;
				end else if (deep_req) begin
					next_r.state = hhpsc_pkg::ST_DEEP;
				end else if (grant_req) begin
					next_r.state = hhpsc_pkg::ST_GRANT;
				end
			end
			hhpsc_pkg::ST_GRANT: begin
				if (sleep_req) begin
					next_r.state = hhpsc_pkg::ST_SUSP;
				end else if (deep_req) begin
					next_r.state = hhpsc_pkg::ST_DEEP;
				end else if (!grant_req) begin
					next_r.state = hhpsc_pkg::ST_RUN;
				end
			end
			hhpsc_pkg::ST_DEEP: begin
				if (r.ratio_pending) begin
					next_r.state = hhpsc_pkg::ST_RATIO;
				end else if (sleep_req) begin
					next_r.state = hhpsc_pkg::ST_SUSP;
				end else if (!deep_req) begin
					next_r.state = hhpsc_pkg::ST_RUN;
				end
			end
			hhpsc_pkg::ST_RATIO: begin
				// One-cycle step while the processor clock is stopped
				next_r.ctrl.ratio_step = 1'b1; // see [RL6]
				next_r.ctrl.ratio_mode = r.mains_seen ? hhpsc_pkg::RATIO_MAX
					: hhpsc_pkg::RATIO_BATTERY; // see [RL7]
				// A mains edge in this very cycle must survive the clear
				if (i_mains_present == r.mains_seen) begin
					next_r.ratio_pending = 1'b0;
				end
				next_r.state           = hhpsc_pkg::ST_DEEP;
			end
			hhpsc_pkg::ST_SUSP: begin
				if (i_power_state == hhpsc_pkg::PS_S3) begin
					next_r.state = hhpsc_pkg::ST_MEMRET;
				end else if (i_power_state == hhpsc_pkg::PS_C0) begin
					next_r.state = hhpsc_pkg::ST_RUN;
				end
			end
			hhpsc_pkg::ST_MEMRET: begin
				if (i_power_state == hhpsc_pkg::PS_C0) begin
					next_r.state = hhpsc_pkg::ST_RUN;
				end
			end
			default: begin
				next_r.state = hhpsc_pkg::ST_RUN;
			end
		endcase
		// Outputs follow the next state so the ports stay flop-driven
		next_r.ctrl.snoop_enable = (next_r.state == hhpsc_pkg::ST_RUN) ||
			(next_r.state == hhpsc_pkg::ST_GRANT); // see [RL2] [RL4]
		next_r.ctrl.clock_gate = (next_r.state != hhpsc_pkg::ST_RUN); // see [RL9]
		next_r.ctrl.host_clock_run = (next_r.state == hhpsc_pkg::ST_RUN) ||
			(next_r.state == hhpsc_pkg::ST_GRANT) ||
			(next_r.state == hhpsc_pkg::ST_DEEP) ||
			(next_r.state == hhpsc_pkg::ST_RATIO); // see [RL11]
		next_r.ctrl.self_refresh = !((next_r.state == hhpsc_pkg::ST_RUN) ||
			(next_r.state == hhpsc_pkg::ST_GRANT)); // see [RL11]
		next_r.ctrl.memory_retain = (next_r.state == hhpsc_pkg::ST_MEMRET); // see [RL10]
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			r.state         <= hhpsc_pkg::ST_RUN;
			r.mains_seen    <= hhpsc_pkg::MAINS_SEEN_RESET;
			r.ratio_pending <= 1'b0;
			r.ctrl          <= hhpsc_pkg::CTRL_RESET;
		end else if (i_clk_en) begin
			r <= next_r;
		end
	end

	always_comb begin
		o_snoop_enable       = r.ctrl.snoop_enable;
		o_clock_gate         = r.ctrl.clock_gate;
		o_hub_host_clock_run = r.ctrl.host_clock_run;
		o_self_refresh       = r.ctrl.self_refresh;
		o_ratio_step         = r.ctrl.ratio_step;
		o_ratio_mode         = r.ctrl.ratio_mode;
		o_memory_retain      = r.ctrl.memory_retain;
		o_state              = r.state;
	end

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);

	// Properties count enabled edges only, since a low enable freezes every output
	sequence s_deep_enter;
		i_clk_en && (r.state == hhpsc_pkg::ST_RUN || r.state == hhpsc_pkg::ST_GRANT)
		&& deep_req && !sleep_req;
	endsequence

	sequence s_ratio_due;
		i_clk_en && (r.state == hhpsc_pkg::ST_DEEP) && r.ratio_pending;
	endsequence

	sequence s_ratio_run;
		i_clk_en && (r.state == hhpsc_pkg::ST_RATIO);
	endsequence

	sequence s_mains_edge;
		i_clk_en && (i_mains_present != r.mains_seen);
	endsequence

	sequence s_mains_quiet;
		i_clk_en && !r.ratio_pending && (i_mains_present == r.mains_seen);
	endsequence

	a_snoop_in_run: assert property ( // see [RL2]
		(r.state == hhpsc_pkg::ST_RUN || r.state == hhpsc_pkg::ST_GRANT) |-> o_snoop_enable)
		else $error("snoops off while processor can snoop");
	a_grant_entry: assert property ( // see [RL2]
		(i_clk_en && r.state == hhpsc_pkg::ST_RUN && grant_req
		&& !deep_req && !sleep_req)
		|=> (r.state == hhpsc_pkg::ST_GRANT && o_snoop_enable))
		else $error("stop grant entry lost snoops");
	a_no_snoop_deep: assert property ( // see [RL4]
		(r.state == hhpsc_pkg::ST_DEEP || r.state == hhpsc_pkg::ST_RATIO) |-> !o_snoop_enable)
		else $error("snoop enabled in deep sleep");
	a_deep_entry: assert property ( // see [RL4]
		s_deep_enter |=> (r.state == hhpsc_pkg::ST_DEEP && !o_snoop_enable))
		else $error("deep sleep entry kept snoops");
	a_c4_as_c3: assert property ( // see [RL5]
		(i_clk_en && r.state == hhpsc_pkg::ST_RUN && i_power_state == hhpsc_pkg::PS_C4)
		|=> (r.state == hhpsc_pkg::ST_DEEP))
		else $error("C4 request not handled like C3");
	a_ratio_in_deep: assert property ( // see [RL6]
		o_ratio_step |-> (r.state == hhpsc_pkg::ST_DEEP && o_self_refresh && !o_snoop_enable))
		else $error("ratio step outside stopped clock state");
	a_ratio_from_stop: assert property ( // see [RL6]
		$rose(o_ratio_step) |-> ($past(r.state) == hhpsc_pkg::ST_RATIO))
		else $error("ratio step without ratio state");
	a_ratio_on_mains: assert property ( // see [RL7]
		s_ratio_due |=> (r.state == hhpsc_pkg::ST_RATIO))
		else $error("pending ratio change not started");
	a_ratio_step_mode: assert property ( // see [RL7]
		s_ratio_run |=> (o_ratio_step && r.state == hhpsc_pkg::ST_DEEP
		&& o_ratio_mode == ($past(r.mains_seen) ? hhpsc_pkg::RATIO_MAX
		: hhpsc_pkg::RATIO_BATTERY)))
		else $error("ratio step or mode wrong");
	a_mains_latched: assert property ( // see [RL7]
		s_mains_edge |=> (r.ratio_pending && r.mains_seen == $past(i_mains_present)))
		else $error("mains change not latched");
	a_no_spurious_ratio: assert property ( // see [RL7]
		s_mains_quiet |=> !r.ratio_pending)
		else $error("ratio change without mains change");
	a_s2_ignored: assert property ( // see [RL8]
		(i_clk_en && r.state == hhpsc_pkg::ST_RUN && i_power_state == hhpsc_pkg::PS_S2
		&& !i_stop_clock_request && i_mains_present == r.mains_seen)
		|=> (r.state == hhpsc_pkg::ST_RUN))
		else $error("S2 request changed state");
	a_gate_in_grant: assert property ( // see [RL9]
		(r.state == hhpsc_pkg::ST_GRANT) |-> (o_clock_gate && o_snoop_enable))
		else $error("no gating in stop grant");
	a_mem_retain: assert property ( // see [RL10]
		(r.state == hhpsc_pkg::ST_MEMRET) |-> (o_memory_retain && o_self_refresh
		&& !o_hub_host_clock_run))
		else $error("memory not retained in suspend");
	a_host_clock_deep: assert property ( // see [RL11]
		(r.state == hhpsc_pkg::ST_DEEP) |-> (o_hub_host_clock_run && o_self_refresh))
		else $error("deep sleep clock or refresh wrong");
	a_sleep_host_stop: assert property ( // see [RL11]
		(r.state == hhpsc_pkg::ST_SUSP) |-> (!o_hub_host_clock_run && o_self_refresh
		&& !o_snoop_enable))
		else $error("sleep state host clock or refresh wrong");
endmodule
`default_nettype wire

/* File: hhpsc_pkg.sv */
// Package: power state codes, state record and reset constants for the hub power control
`default_nettype none
package hhpsc_pkg;
	// Requested power state code on the state input
	localparam logic [3:0] PS_C0                     = 4'h0;
	localparam logic [3:0] PS_C1                     = 4'h1;
	localparam logic [3:0] PS_C2                     = 4'h2;
	localparam logic [3:0] PS_C3                     = 4'h3;
	localparam logic [3:0] PS_C4                     = 4'h4;
	localparam logic [3:0] PS_MOBILE_POWERED_SUSPEND = 4'h5;
	localparam logic [3:0] PS_S2                     = 4'h6;
	localparam logic [3:0] PS_S3                     = 4'h7;
	localparam logic [3:0] PS_S4                     = 4'h8;
	localparam logic [3:0] PS_S5                     = 4'h9;

	typedef enum logic [5:0] {
		ST_RUN    = 6'h01,
		ST_GRANT  = 6'h02,
		ST_DEEP   = 6'h04,
		ST_RATIO  = 6'h08,
		ST_SUSP   = 6'h10,
		ST_MEMRET = 6'h20
	} hhpsc_state_type;

	localparam logic RATIO_MAX        = 1'b0;
	localparam logic RATIO_BATTERY    = 1'b1;
	// Mains copy starts high, so mains absent at release queues a ratio change
	localparam logic MAINS_SEEN_RESET = 1'b1;

	typedef struct packed {
		logic snoop_enable;
		logic clock_gate;
		logic host_clock_run;
		logic self_refresh;
		logic ratio_step;
		logic ratio_mode;
		logic memory_retain;
	} hhpsc_ctrl_type;

	typedef struct packed {
		hhpsc_state_type state;
		logic            mains_seen;
		logic            ratio_pending;
		hhpsc_ctrl_type  ctrl;
	} hhpsc_regs_type;

	localparam hhpsc_ctrl_type CTRL_RESET = '{
		snoop_enable:   1'b1,
		clock_gate:     1'b0,
		host_clock_run: 1'b1,
		self_refresh:   1'b0,
		ratio_step:     1'b0,
		ratio_mode:     1'b0,
		memory_retain:  1'b0
	};
endpackage
`default_nettype wire

/* File: hhpsc_partner.sv */
// Processor and companion controller model driving the requested power state
`default_nettype none
module hhpsc_partner (
	input  wire logic [3:0] i_cmd,
	output logic      [3:0] o_power_state,
	output logic            o_stop_clock_request
);
	timeunit 1ns;
	timeprecision 1ps;
	// Codes pass straight through, so a bench can still request S2 to probe refusal
	assign o_power_state = i_cmd;
	// Stop-clock only for stop grant, low in C0 and every other state
	assign o_stop_clock_request = (i_cmd == hhpsc_pkg::PS_C2);
	// No graphics or interconnect agent is modelled, so nothing but silence in C3
	// Ratio changes are tied to mains edges, which the bench drives
endmodule
`default_nettype wire

/* File: hhpsc_ctrl_bench.sv */
// Bench for the hub power control: stimulus, expected-result queue, output watcher
`default_nettype none
module hhpsc_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_ref_clk = 1'b0;
	logic        i_rstn = 1'b0;
	logic        i_clk_en = 1'b1;
	logic        i_mains_present = 1'b1;
	logic [3:0]  cmd = hhpsc_pkg::PS_C0;
	logic [5:0]  last = 6'h01;
	logic [12:0] q[$];
	int          errors = 0;
	int          comparisons = 0;
	wire logic [3:0]  ps;
	wire logic        stop;
	wire logic [12:0] seen;

	always #5 i_ref_clk = ~i_ref_clk;

	hhpsc_partner partner (.i_cmd(cmd), .o_power_state(ps), .o_stop_clock_request(stop));
	hhpsc_ctrl dut (
		.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_clk_en(i_clk_en),
		.i_power_state(ps), .i_stop_clock_request(stop), .i_mains_present(i_mains_present),
		.o_snoop_enable(seen[6]), .o_clock_gate(seen[5]), .o_hub_host_clock_run(seen[4]),
		.o_self_refresh(seen[3]), .o_ratio_step(seen[2]), .o_ratio_mode(seen[1]),
		.o_memory_retain(seen[0]), .o_state(seen[12:7])
	);

	// Output image of a state; retain only in memory retention
	function automatic logic [12:0] expect_of(input logic [5:0] st, input logic stp, input logic md);
		logic r;
		logic d;
		r = st inside {6'h01, 6'h02};
		d = st inside {6'h04, 6'h08};
		return {st, r, st != 6'h01, r | d, ~r, stp, md, st == 6'h20};
	endfunction

	task note(input logic [5:0] st, input logic stp, input logic md);
		q.push_back(expect_of(st, stp, md));
	endtask

	task check(input logic [12:0] got, input logic [12:0] want);
		comparisons++;
		if (got !== want) begin
			errors++;
			$display("[FAIL] %0t outputs %h, expected %h", $time, got, want);
		end
	endtask

	task final_report;
		if (errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Random enable gaps; only enabled edges count towards the wait
	task hold(input int n);
		int k;
		k = 0;
		while (k < n) begin
			@(posedge i_ref_clk);
			if (i_clk_en === 1'b1) k++;
			#1;
			i_clk_en = ($urandom % 4) != 0;
		end
	endtask

	task req(input logic [3:0] c);
		cmd = c;
		hold(4);
	endtask

	// Every state change consumes the oldest note; an unplanned change meets zero
	always @(posedge i_ref_clk) begin
		#2;
		if (i_rstn && seen[12:7] !== last) begin
			last = seen[12:7];
			check(seen, (q.size() > 0) ? q.pop_front() : 13'h0000);
		end
	end

	initial begin
		void'($urandom(32'h5CFE285E));
		repeat (16) @(posedge i_ref_clk);
		#1;
		i_rstn = 1'b1;
		req(hhpsc_pkg::PS_C1);
		note(6'h02, 1'b0, 1'b0);
		req(hhpsc_pkg::PS_C2);
		note(6'h04, 1'b0, 1'b0);
		req(hhpsc_pkg::PS_C3);
		note(6'h08, 1'b0, 1'b0);
		note(6'h04, 1'b1, 1'b1);
		i_mains_present = 1'b0;
		hold(4);
		note(6'h01, 1'b0, 1'b1);
		req(hhpsc_pkg::PS_C0);
		i_mains_present = 1'b1;
		hold(4);
		note(6'h04, 1'b0, 1'b1);
		note(6'h08, 1'b0, 1'b1);
		note(6'h04, 1'b1, 1'b0);
		req(hhpsc_pkg::PS_C4);
		note(6'h01, 1'b0, 1'b0);
		req(hhpsc_pkg::PS_C0);
		req(hhpsc_pkg::PS_S2);
		note(6'h10, 1'b0, 1'b0);
		req(hhpsc_pkg::PS_MOBILE_POWERED_SUSPEND);
		note(6'h20, 1'b0, 1'b0);
		req(hhpsc_pkg::PS_S3);
		note(6'h01, 1'b0, 1'b0);
		req(hhpsc_pkg::PS_C0);
		check(13'(q.size()), 13'h0000);
		final_report;
	end

	// Whole plan needs well under a thousand cycles
	initial begin
		#100us;
		errors++;
		final_report;
	end
endmodule
`default_nettype wire
